/* File: inc/lbx_regs.svh */
/*
  timing-free constants for the logic and branch execution block: opcode
  and field encodings, field positions and reset values.
  assumes nothing beyond a standard preprocessor.
*/
`ifndef LBX_REGS_SVH
`define LBX_REGS_SVH

`define LBX_OP_SPECIAL      6'h00
`define LBX_FN_AND          6'h24
`define LBX_OP_AND_IMMEDIATE_OP         6'h0c
`define LBX_OP_BEQ          6'h04
`define LBX_OP_EQUAL_BRANCH_LIKELY         6'h14
`define LBX_OP_REGISTER_IMMEDIATE_GROUP       6'h01
`define LBX_RT_NONNEGATIVE_BRANCH         5'h01
`define LBX_RT_NONNEGATIVE_BRANCH_LINK       5'h11
`define LBX_OP_COP_HI       4'h4
`define LBX_COP_BC          5'h08
`define LBX_BC_F            5'h00
`define LBX_BC_T            5'h01
`define LBX_BC_FL           5'h02
`define LBX_BC_TL           5'h03
`define LBX_LINK_REG        5'h1f
`define LBX_OP_POS          26
`define LBX_RS_POS          21
`define LBX_RT_POS          16
`define LBX_RD_POS          11
`define LBX_PC_RESET        64'h0
`define LBX_LINK_OFFSET     64'h8
`define LBX_SLOT_OFFSET     64'h4

`endif

/* File: inc/lbx_pkg.sv */
/*
  types shared by the logic and branch execution block.
  assumes lbx_regs.svh is on the include path for the numbers.
*/
package lbx_pkg;
  typedef struct packed {
    logic        valid;
    logic [63:0] pc;
    logic [31:0] word;
  } lbx_issue_t;

  typedef struct packed {
    logic        we;
    logic [4:0]  addr;
    logic [63:0] data;
  } lbx_wb_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] target;
  } lbx_redirect_t;
endpackage

/* File: src/lbx_branch_cond.sv */
/*
  branch condition evaluator: decides taken and likely for one issued word.
  assumes register operands and the sampled flag are settled in the same cycle.
*/
`timescale 1ns/1ps
`include "lbx_regs.svh"
module lbx_branch_cond (
  // decoded word
  input  wire logic [31:0] word,
  input  wire logic [63:0] rs_val,
  input  wire logic [63:0] rt_val,
  input  wire logic        mode64,
  input  wire logic        cond_flag_prev,
  // decision
  output logic             is_branch,
  output logic             is_cop_branch,
  output logic             is_likely,
  output logic             is_link,
  output logic             taken
);
  logic [5:0] op;
  logic [4:0] rsf;
  logic [4:0] rtf;
  logic       sign;

  always_comb begin
    op            = word[31:26];
    rsf           = word[25:21];
    rtf           = word[20:16];
    sign          = mode64 ? rs_val[63] : rs_val[31];
    is_branch     = 1'b0;
    is_cop_branch = 1'b0;
    is_likely     = 1'b0;
    is_link       = 1'b0;
    taken         = 1'b0;
    if (op == `LBX_OP_BEQ || op == `LBX_OP_EQUAL_BRANCH_LIKELY) begin
      is_branch = 1'b1;
      is_likely = (op == `LBX_OP_EQUAL_BRANCH_LIKELY);
      taken     = (rs_val == rt_val); // RULE11
    end else if (op == `LBX_OP_REGISTER_IMMEDIATE_GROUP && (rtf == `LBX_RT_NONNEGATIVE_BRANCH || rtf == `LBX_RT_NONNEGATIVE_BRANCH_LINK)) begin
      is_branch = 1'b1;
      is_link   = (rtf == `LBX_RT_NONNEGATIVE_BRANCH_LINK);
      taken     = ~sign; // RULE12
    end else if (op[5:2] == `LBX_OP_COP_HI && rsf == `LBX_COP_BC && rtf[4:2] == 3'h0) begin
      is_branch     = 1'b1;
      is_cop_branch = 1'b1;
      is_likely     = rtf[1]; // RULE6 RULE8
      // bit 0 selects true versus false sense
      taken         = rtf[0] ? cond_flag_prev : ~cond_flag_prev; // RULE5 RULE7
    end
  end
endmodule // lbx_branch_cond

/* File: src/lbx_exec.sv */
/*
  logic and branch execution stage: register and immediate AND, coprocessor
  flag branches, equality branches and the non-negative branch with link.
  assumes the fetch side issues one word per valid cycle with its pc, and
  that register operands arrive combinationally from the register file.
*/
// Overview of operation
// RULE1 - the register AND writes rs AND rt into rd.
// RULE2 - the immediate AND zero-extends the 16-bit immediate, ANDs it with rs and writes rt.
// RULE3 - branch targets are the sign-extended offset times four plus the delay slot address.
// RULE4 - a taken branch redirects the pc only after the delay slot word has issued.
// RULE5 - the false coprocessor branch is taken when the flag sampled one word earlier is clear.
// RULE6 - the likely false coprocessor branch nullifies the delay slot when not taken.
// RULE7 - the true coprocessor branch is taken when the flag sampled one word earlier is set.
// RULE8 - the likely true coprocessor branch nullifies the delay slot when not taken.
// RULE9 - software keeps one word between a flag change and a flag branch.
// RULE10 - any coprocessor branch raises coprocessor unusable when the coprocessor is disabled.
// RULE11 - the equality branches are taken when rs equals rt, the likely one nullifying otherwise.
// RULE12 - the non-negative branch is taken when the sign bit of rs is clear, 31 or 63 by mode.
// RULE13 - the linking non-negative branch always writes pc plus 8 into register 31.
// RULE14 - rs equal to 31 in the linking form is neither detected nor trapped.
// RULE15 - an exception in a delay slot records the branch address as the return point.
// RULE16 - in 64-bit mode the register AND covers 64 bits and the immediate AND clears 63 to 16.
`timescale 1ns/1ps
`include "lbx_regs.svh"
module lbx_exec
  import lbx_pkg::*;
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // issue from fetch
  input  wire lbx_pkg::lbx_issue_t    issue,
  input  wire logic                   mode64,
  // register file read
  input  wire logic [63:0]            rs_val,
  input  wire logic [63:0]            rt_val,
  // coprocessor side
  input  wire logic                   coprocessor_condition_flag,
  input  wire logic                   cop_usable,
  input  wire logic                   slot_exception,
  // results
  output lbx_pkg::lbx_wb_t            wb,
  output lbx_pkg::lbx_redirect_t      redirect,
  output logic                        nullify,
  output logic                        cop_unusable_exc,
  output logic                        exc_valid,
  output logic [63:0]                 exception_return_pointer
);
  import lbx_pkg::*;

  logic [5:0]  op;
  logic [5:0]  fn;
  logic [4:0]  rsf;
  logic [4:0]  rtf;
  logic [4:0]  rdf;
  logic [15:0] imm;
  logic [63:0] target;
  logic        is_branch;
  logic        is_cop_branch;
  logic        is_likely;
  logic        is_link;
  logic        taken;
  logic        cond_prev_q;
  logic        slot_pending_q;
  logic        slot_taken_q;
  logic        slot_likely_q;
  logic [63:0] slot_target_q;
  logic [63:0] branch_pc_q;
  lbx_wb_t     wb_d;
  lbx_wb_t     wb_q;
  lbx_redirect_t redirect_q;
  logic        nullify_q;
  logic        cop_exc_q;
  logic        exc_q;
  logic [63:0] epc_q;
  logic        branch_go;

  assign op  = issue.word[31:`LBX_OP_POS];
  assign fn  = issue.word[5:0];
  assign rsf = issue.word[25:`LBX_RS_POS];
  assign rtf = issue.word[20:`LBX_RT_POS];
  assign rdf = issue.word[15:`LBX_RD_POS];
  assign imm = issue.word[15:0];

  // delay slot address is pc plus 4
  assign target = issue.pc + `LBX_SLOT_OFFSET + {{46{imm[15]}}, imm, 2'b00}; // RULE3

  lbx_branch_cond u_cond (
    .word           (issue.word),
    .rs_val         (rs_val),
    .rt_val         (rt_val),
    .mode64         (mode64),
    .cond_flag_prev (cond_prev_q),
    .is_branch      (is_branch),
    .is_cop_branch  (is_cop_branch),
    .is_likely      (is_likely),
    .is_link        (is_link),
    .taken          (taken)
  );

  // a coprocessor branch that traps does not act as a branch
  assign branch_go = issue.valid && is_branch && !(is_cop_branch && !cop_usable); // RULE10

  // flag is caught each issued word so a branch sees the value from the word before
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cond_prev_q <= 1'b0;
    end else if (issue.valid) begin
      cond_prev_q <= coprocessor_condition_flag; // RULE5 RULE7 RULE9
    end
  end

  // write-back selection
  always_comb begin
    wb_d      = '0;
    wb_d.addr = rdf;
    // an interrupted slot word must not complete; it runs again after the return
    if (issue.valid && !slot_nullify_now() && !slot_exception) begin // RULE15
      if (op == `LBX_OP_SPECIAL && fn == `LBX_FN_AND) begin
        wb_d.we = 1'b1;
        wb_d.addr = rdf;
        // full width AND; 32-bit mode uses the low half of the same value
        wb_d.data = rs_val & rt_val; // RULE1 RULE16
      end else if (op == `LBX_OP_AND_IMMEDIATE_OP) begin
        wb_d.we = 1'b1;
        wb_d.addr = rtf;
        wb_d.data = {48'h0, imm & rs_val[15:0]}; // RULE2 RULE16
      end else if (branch_go && is_link) begin
        // written whether taken or not; rs of 31 is not checked
        wb_d.we = 1'b1;
        wb_d.addr = `LBX_LINK_REG;
        wb_d.data = issue.pc + `LBX_LINK_OFFSET; // RULE13 RULE14
      end
    end
  end

  function automatic logic slot_nullify_now();
    slot_nullify_now = slot_pending_q && slot_likely_q && !slot_taken_q;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_q <= '0;
    end else begin
      wb_q <= wb_d;
    end
  end

  // branch decision is held until the slot word issues
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slot_pending_q <= 1'b0;
      slot_taken_q   <= 1'b0;
      slot_likely_q  <= 1'b0;
      slot_target_q  <= `LBX_PC_RESET;
      branch_pc_q    <= `LBX_PC_RESET;
    end else if (issue.valid) begin
      slot_pending_q <= branch_go && !slot_pending_q;
      slot_taken_q   <= taken;
      slot_likely_q  <= is_likely;
      slot_target_q  <= target;
      branch_pc_q    <= issue.pc;
    end
  end

  // redirect and nullify fire with the slot word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      redirect_q <= '0;
      nullify_q  <= 1'b0;
    end else begin
      redirect_q.valid  <= issue.valid && slot_pending_q && slot_taken_q && !slot_exception; // RULE4
      redirect_q.target <= slot_target_q; // RULE3
      nullify_q         <= issue.valid && slot_nullify_now(); // RULE6 RULE8 RULE11
    end
  end

  // exceptions
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cop_exc_q <= 1'b0;
      exc_q     <= 1'b0;
      epc_q     <= `LBX_PC_RESET;
    end else begin
      cop_exc_q <= issue.valid && is_cop_branch && !cop_usable; // RULE10
      exc_q     <= issue.valid && (slot_exception || (is_cop_branch && !cop_usable));
      if (issue.valid && slot_exception) begin
        // return to the branch so branch and slot both run again
        epc_q <= slot_pending_q ? branch_pc_q : issue.pc; // RULE15
      end else if (issue.valid && is_cop_branch && !cop_usable) begin
        epc_q <= issue.pc;
      end
    end
  end

  assign wb                       = wb_q;
  assign redirect                 = redirect_q;
  assign nullify                  = nullify_q;
  assign cop_unusable_exc         = cop_exc_q;
  assign exc_valid                = exc_q;
  assign exception_return_pointer = epc_q;
endmodule // lbx_exec

/* File: tb/lbx_exec_sva.sv */
/*
  assertions on the ports of the logic and branch execution stage.
  assumes one clock and a synchronous active-low reset; bound to lbx_exec.
*/
`timescale 1ns/1ps
`include "lbx_regs.svh"
module lbx_exec_sva
  import lbx_pkg::*;
(
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  // issue side
  input wire lbx_pkg::lbx_issue_t    issue,
  input wire logic                   mode64,
  input wire logic [63:0]            rs_val,
  input wire logic [63:0]            rt_val,
  input wire logic                   coprocessor_condition_flag,
  input wire logic                   cop_usable,
  input wire logic                   slot_exception,
  // results
  input wire lbx_pkg::lbx_wb_t       wb,
  input wire lbx_pkg::lbx_redirect_t redirect,
  input wire logic                   nullify,
  input wire logic                   cop_unusable_exc,
  input wire logic                   exc_valid,
  input wire logic [63:0]            exception_return_pointer
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] w;
  logic        is_eq, is_gez, is_cop, is_and, is_and_immediate_op, tk, lk;
  logic        br_q, fl_q, tk_q, lk_q;
  logic [63:0] pc_q, tgt;
  logic [15:0] off_q;
  assign w   = issue.word;
  assign tgt = pc_q + `LBX_SLOT_OFFSET + {{46{off_q[15]}}, off_q, 2'b00};
  always_comb begin
    is_eq   = w[31:26] == `LBX_OP_BEQ || w[31:26] == `LBX_OP_EQUAL_BRANCH_LIKELY;
    is_gez  = w[31:26] == `LBX_OP_REGISTER_IMMEDIATE_GROUP && (w[20:16] == `LBX_RT_NONNEGATIVE_BRANCH || w[20:16] == `LBX_RT_NONNEGATIVE_BRANCH_LINK);
    is_cop  = w[31:28] == `LBX_OP_COP_HI && w[25:21] == `LBX_COP_BC && w[20:18] == 3'h0;
    is_and  = w[31:26] == `LBX_OP_SPECIAL && w[5:0] == `LBX_FN_AND;
    is_and_immediate_op = w[31:26] == `LBX_OP_AND_IMMEDIATE_OP;
    tk      = is_eq ? rs_val == rt_val : is_gez ? !(mode64 ? rs_val[63] : rs_val[31])
            : is_cop && cop_usable && (w[16] ? fl_q : !fl_q);
    lk      = w[31:26] == `LBX_OP_EQUAL_BRANCH_LIKELY || (is_cop && cop_usable && w[17]);
  end
  // a branch sitting in a slot is not a branch, so br_q never chains
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {br_q, fl_q, tk_q, lk_q} <= 4'h0;
      pc_q <= 64'h0;
      off_q <= 16'h0;
    end else if (issue.valid) begin
      // a trapping coprocessor branch opens no delay slot
      {br_q, fl_q, tk_q, lk_q} <= {(is_eq || is_gez || (is_cop && cop_usable)) && !br_q,
                                   coprocessor_condition_flag, tk, lk};
      pc_q <= issue.pc;
      off_q <= w[15:0];
    end
  end
  sequence slot_taken;
    issue.valid && br_q && tk_q && !slot_exception;
  endsequence
  sequence slot_fall;
    issue.valid && br_q && !tk_q && !slot_exception;
  endsequence
  chk_and_reg_result: assert property (issue.valid && is_and && !slot_exception |=> nullify || (wb.we &&
    wb.addr == 5'($past(issue.word) >> 11) && wb.data == ($past(rs_val) & $past(rt_val))))
    else $error("register and result wrong");
  chk_and_imm_result: assert property (issue.valid && is_and_immediate_op && !slot_exception |=> nullify || (wb.we &&
    wb.addr == 5'($past(issue.word) >> 16) && wb.data == ($past(rs_val) & {48'h0, 16'($past(issue.word))})))
    else $error("immediate and result wrong");
  chk_link_write: assert property (issue.valid && is_gez && w[20] && !br_q && !slot_exception |=> wb.we &&
    wb.addr == `LBX_LINK_REG && wb.data == $past(issue.pc) + `LBX_LINK_OFFSET)
    else $error("link write wrong");
  chk_taken_redirect: assert property (slot_taken |=> redirect.valid && redirect.target == $past(tgt))
    else $error("taken branch did not redirect to its target");
  chk_fall_through: assert property (slot_fall |=> !redirect.valid && nullify == $past(lk_q))
    else $error("untaken branch redirect or nullify wrong");
  chk_redirect_cause: assert property (redirect.valid |-> $past(issue.valid) && $past(br_q))
    else $error("redirect not after a delay slot word");
  chk_cop_unusable: assert property (issue.valid && is_cop && !br_q && !cop_usable |=> cop_unusable_exc && exc_valid)
    else $error("coprocessor unusable not raised");
  chk_unusable_cause: assert property (cop_unusable_exc |-> $past(issue.valid) && !$past(cop_usable))
    else $error("coprocessor unusable without cause");
  chk_slot_return: assert property (issue.valid && br_q && slot_exception |=> exc_valid && !redirect.valid &&
    exception_return_pointer == $past(pc_q))
    else $error("slot exception return point wrong");
endmodule // lbx_exec_sva

bind lbx_exec lbx_exec_sva chk_u (.ref_clk, .rst_n, .issue, .mode64, .rs_val, .rt_val,
  .coprocessor_condition_flag, .cop_usable, .slot_exception, .wb, .redirect, .nullify,
  .cop_unusable_exc, .exc_valid, .exception_return_pointer);

/* File: tb/lbx_fetch_model.sv */
/*
  fetch side model: issues one word per request with its pc and operands.
  assumes the bench leaves two idle cycles after each delay slot word.
*/
`timescale 1ns/1ps
module lbx_fetch_model
  import lbx_pkg::*;
(
  // requests from the bench
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   go,
  input  wire logic [31:0]            word_in,
  input  wire logic [63:0]            a_in,
  input  wire logic [63:0]            b_in,
  input  wire logic                   sx_in,
  input  wire lbx_pkg::lbx_redirect_t redirect,
  // towards the block
  output lbx_pkg::lbx_issue_t         issue,
  output logic [63:0]                 rs_val,
  output logic [63:0]                 rt_val,
  output logic                        slot_exception
);
  logic [63:0] pc_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) pc_q <= 64'h0;
    else if (redirect.valid) pc_q <= redirect.target;
    else if (go) pc_q <= pc_q + 64'h4;
  end
  // idle cycles show inverted leftovers so stale operands never look valid
  always_ff @(posedge ref_clk) begin
    issue <= go ? {1'b1, pc_q, word_in} : {1'b0, ~issue.pc, ~issue.word};
    rs_val <= go ? a_in : ~rs_val;
    rt_val <= go ? b_in : ~rt_val;
    slot_exception <= go & sx_in;
  end
endmodule // lbx_fetch_model

/* File: tb/logic_and_branch_exec_tb.sv */
/*
  self-checking bench: filler and, branch, delay slot, then idle cycles.
  assumes the fetch model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "lbx_regs.svh"
module logic_and_branch_exec_tb;
  import lbx_pkg::*;
  typedef struct packed {
    lbx_wb_t w; lbx_redirect_t r; logic n; logic e; logic u; logic [63:0] p;
  } lbx_exp_t;
  logic ref_clk = 0, rst_n = 0, go = 0, sx_in = 0, mode64 = 0, flag = 0, cop_usable = 1;
  logic [31:0] word_in = 0;
  logic [63:0] a_in = 0, b_in = 0, rs_val, rt_val, erp, pc_e, a, b, tgt;
  lbx_issue_t issue;
  lbx_wb_t wb;
  lbx_redirect_t redirect;
  logic slot_exception, nullify, cop_unusable_exc, exc_valid, tk, lk, u, f, sx;
  logic [2:0] k;
  logic [15:0] off;
  logic [31:0] w;
  int err_count, samples_checked;
  lbx_exp_t q[$], e;
  always #25 ref_clk = ~ref_clk;
  lbx_fetch_model fm_u (.ref_clk, .rst_n, .go, .word_in, .a_in, .b_in, .sx_in, .redirect, .issue,
    .rs_val, .rt_val, .slot_exception);
  lbx_exec dut_u (.ref_clk, .rst_n, .issue, .mode64, .rs_val, .rt_val, .coprocessor_condition_flag(flag),
    .cop_usable, .slot_exception, .wb, .redirect, .nullify, .cop_unusable_exc, .exc_valid,
    .exception_return_pointer(erp));
  task check(string nm, logic [69:0] seen, logic [69:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // outputs of a word show two steps after it is requested
  task step(logic g, logic [31:0] wd, logic [63:0] x, logic [63:0] y, logic s, lbx_exp_t ex);
    lbx_exp_t o;
    @(posedge ref_clk);
    {go, word_in, a_in, b_in, sx_in} <= {g, wd, x, y, s};
    #1;
    if (q.size() == 2) begin
      o = q.pop_front();
      check("wb", 70'(wb.we ? wb : '0), 70'(o.w));
      check("redirect", 70'(redirect.valid ? redirect : '0), 70'(o.r));
      check("nullify", 70'(nullify), 70'(o.n));
      check("exception", 70'({exc_valid, cop_unusable_exc}), 70'({o.e, o.u}));
      if (o.e && !o.u) check("return", 70'(erp), 70'(o.p));
    end
    q.push_back(ex);
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #5000000;
    err_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'h489d));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    pc_e = 64'h0;
    for (int i = 0; i < 400; i++) begin
      {k, u, f, off} = {3'($urandom), $urandom_range(7, 0) != 0, 1'($urandom), 16'($urandom)};
      // the flag moves one word ahead of the branch, never right before it
      flag <= f;
      mode64 <= 1'($urandom);
      cop_usable <= u;
      a = {$urandom, $urandom};
      b = $urandom_range(1, 0) ? a : {$urandom, $urandom};
      w = $urandom;
      e = '0;
      e.w = i[0] ? {1'b1, w[15:11], a & b} : {1'b1, w[20:16], a & {48'h0, w[15:0]}};
      step(1, i[0] ? {`LBX_OP_SPECIAL, w[25:11], 5'h0, `LBX_FN_AND} : {`LBX_OP_AND_IMMEDIATE_OP, w[25:0]}, a, b, 0, e);
      pc_e += 64'h4;
      tk = k[2] ? u && (k[0] ? f : !f) : k[1] ? !(mode64 ? a[63] : a[31]) : a == b;
      lk = k[2] ? u && k[1] : k == 3'd1;
      tgt = pc_e + 64'h4 + {{46{off[15]}}, off, 2'b00};
      e = '0;
      e.w = k == 3'd3 ? {1'b1, 5'h1f, pc_e + 64'h8} : '0;
      {e.e, e.u} = {2{k[2] && !u}};
      step(1, k[2] ? {`LBX_OP_COP_HI, 2'b00, `LBX_COP_BC, 3'b000, k[1:0], off} : k[1] ?
        {`LBX_OP_REGISTER_IMMEDIATE_GROUP, w[25:21], k[0] ? `LBX_RT_NONNEGATIVE_BRANCH_LINK : `LBX_RT_NONNEGATIVE_BRANCH, off} :
        {k[0] ? `LBX_OP_EQUAL_BRANCH_LIKELY : `LBX_OP_BEQ, w[25:16], off}, a, b, 0, e);
      if ($urandom_range(3, 0) == 0) step(0, 0, 0, 0, 0, '0);
      sx = tk && $urandom_range(3, 0) == 0;
      a = {$urandom, $urandom};
      b = {$urandom, $urandom};
      e = '0;
      e.w = (lk && !tk) || sx ? '0 : {1'b1, w[15:11], a & b};
      e.r = tk && !sx ? {1'b1, tgt} : '0;
      {e.n, e.e, e.p} = {lk && !tk, sx, pc_e};
      step(1, {`LBX_OP_SPECIAL, w[25:11], 5'h0, `LBX_FN_AND}, a, b, sx, e);
      // fall through resumes after the slot word
      pc_e = tk && !sx ? tgt : pc_e + 64'h8;
      repeat (2) step(0, 0, 0, 0, 0, '0);
    end
    close_out();
  end
endmodule // logic_and_branch_exec_tb
